// ===== hdl/sarq_consts.svh
// constants of the converter sequencer control
`ifndef SARQ_CONSTS_SVH
`define SARQ_CONSTS_SVH
`define SARQ_SYS_CLK_HZ 10000000
`define SARQ_CONV_CLK_MAX_HZ 18000000
`define SARQ_CLK_DIV_MIN ((`SARQ_SYS_CLK_HZ + `SARQ_CONV_CLK_MAX_HZ - 1) / `SARQ_CONV_CLK_MAX_HZ)
`define SARQ_CONV_CLKS 18
`define SARQ_TRIALS 12
`define SARQ_RES_W 12
`define SARQ_NCH 8
`define SARQ_CH_W 3
`define SARQ_SAMP_W 8
`define SARQ_CNT_W 8
`define SARQ_DIV_W 4
`define SARQ_FIFO_DEPTH 16
`define SARQ_TRIAL_MSB 12'h800
`endif

// ===== hdl/sarq_pkg.sv
// types of the converter sequencer control
`include "sarq_consts.svh"
package sarq_pkg;
    typedef enum logic [1:0] {SARQ_IDLE, SARQ_SAMPLE, SARQ_CONV} sarq_state_t;

    typedef struct packed {
        logic [`SARQ_CH_W-1:0] ch;
        logic [`SARQ_RES_W-1:0] data;
    } sarq_res_t;

    typedef struct packed {
        sarq_state_t st;
        logic [`SARQ_CH_W-1:0] ch;
        logic [`SARQ_CNT_W-1:0] cnt;
        logic [`SARQ_RES_W-1:0] code;
        logic [`SARQ_RES_W-1:0] bitm;
        logic [`SARQ_RES_W-1:0] dac;
        logic scan_auto;
        logic [`SARQ_NCH-1:0][`SARQ_RES_W-1:0] res;
        logic res_stb;
        logic oor;
        logic [`SARQ_CH_W-1:0] oor_ch;
        logic done;
        logic samp;
        logic busy;
        logic [`SARQ_DIV_W-1:0] div;
        logic tick;
    } sarq_top_s_t;
endpackage

// ===== hdl/sarq_top.sv
// converter sequencer control: result fifo and sequencer top
`timescale 1ns/1ps
`include "sarq_consts.svh"

// ----------------------------------------
// result fifo, shift style so the head is always a flop
// ----------------------------------------
module sarq_fifo #(
    parameter int W = 15,
    parameter int DEPTH = `SARQ_FIFO_DEPTH
) (
    input wire logic i_clk,            // system clock
    input wire logic i_rst_n,          // async reset, low
    input wire logic i_valid,          // push request
    input wire logic [W-1:0] i_data,   // push data
    output logic o_ready,              // room for a push
    output logic o_valid,              // head holds data
    output logic [W-1:0] o_data,       // head data
    input wire logic i_ready           // consumer takes head
);
    typedef struct packed {
        logic [DEPTH-1:0][W-1:0] mem;
        logic [$clog2(DEPTH+1)-1:0] cnt;
        logic rdy;
        logic vld;
    } sarq_fifo_s_t;
    sarq_fifo_s_t q, d;
    logic push, pop;

    // shift down on pop, write behind the last entry on push
    always_comb
    begin
        d = q;
        push = i_valid && q.rdy;
        pop = i_ready && q.vld;
        if (pop)
        begin
            for (int i = 0; i < DEPTH - 1; i++)
            begin
                d.mem[i] = q.mem[i+1];
            end
            d.cnt = q.cnt - 1'b1;
        end
        if (push)
        begin
            d.mem[d.cnt[$clog2(DEPTH)-1:0]] = i_data;
            d.cnt = d.cnt + 1'b1;
        end
        d.vld = (d.cnt != '0);
        d.rdy = (d.cnt != DEPTH[$clog2(DEPTH+1)-1:0]);
    end

    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            q <= '{mem: '0, cnt: '0, rdy: 1'b1, vld: 1'b0};
        end
        else
        begin
            q <= d;
        end
    end

    assign o_ready = q.rdy;
    assign o_valid = q.vld;
    assign o_data = q.mem[0];
endmodule

// ----------------------------------------
// sequencer top
// ----------------------------------------
module sarq_top
    import sarq_pkg::*;
#(
    parameter int CLK_DIV = `SARQ_CLK_DIV_MIN
) (
    input wire logic i_clk,                                            // 10 MHz system clock
    input wire logic i_rst_n,                                          // async reset, low
    input wire logic i_en,                                             // converter enable
    input wire logic i_deep_sleep,                                     // deep sleep, idles the sequencer; a storing cycle completes first
    input wire logic i_auto,                                           // 1 scan, 0 firmware channel
    input wire logic i_continuous,                                     // restart scan at end
    input wire logic i_start,                                          // start pulse
    input wire logic [`SARQ_NCH-1:0] i_ch_en,                          // scan channel mask
    input wire logic [`SARQ_CH_W-1:0] i_fw_ch,                         // firmware channel
    input wire logic [`SARQ_NCH-1:0][`SARQ_SAMP_W-1:0] i_samp_time,    // per channel window
    input wire logic [`SARQ_RES_W-1:0] i_range_lo,                     // low limit
    input wire logic [`SARQ_RES_W-1:0] i_range_hi,                     // high limit
    input wire logic i_cmp,                                            // comparator: input >= dac
    output logic [`SARQ_CH_W-1:0] o_mux_sel,                           // channel mux select
    output logic o_sample,                                             // sample switch closed
    output logic [`SARQ_RES_W-1:0] o_dac,                              // trial code
    output logic o_busy,                                               // sequencer active
    output logic [`SARQ_NCH-1:0][`SARQ_RES_W-1:0] o_res,               // per channel results
    output logic o_res_stb,                                            // result stored pulse
    output logic o_oor_irq,                                            // out of range pulse
    output logic [`SARQ_CH_W-1:0] o_oor_ch,                            // channel out of range
    output logic o_scan_done,                                          // scan complete pulse
    output logic o_fifo_valid,                                         // result fifo head valid
    output sarq_pkg::sarq_res_t o_fifo_data,                           // result fifo head
    input wire logic i_fifo_ready                                      // consumer takes head
);
    import sarq_pkg::*;

    localparam logic [`SARQ_DIV_W-1:0] DIV_LAST = `SARQ_DIV_W'(CLK_DIV - 1);
    localparam logic [`SARQ_CNT_W-1:0] CONV_LAST = `SARQ_CNT_W'(`SARQ_CONV_CLKS - 2);
    localparam logic [`SARQ_CNT_W-1:0] TRIAL_N = `SARQ_CNT_W'(`SARQ_TRIALS);

    sarq_top_s_t q, d;
    logic halt, fifo_rdy, push, fin;
    sarq_res_t push_data;
    logic [`SARQ_CH_W:0] nx_cont, nx_first;

    // lowest enabled channel above cur, or from zero; msb says found
    function automatic logic [`SARQ_CH_W:0] sarq_next(input logic [`SARQ_CH_W-1:0] cur,
                                                      input logic [`SARQ_NCH-1:0] mask,
                                                      input logic from0);
        logic [`SARQ_CH_W:0] r;
        r = '0;
        for (int i = `SARQ_NCH - 1; i >= 0; i--)
        begin
            if (mask[i] && (from0 || i > int'(cur)))
            begin
                r = {1'b1, `SARQ_CH_W'(i)};
            end
        end
        return r;
    endfunction

    // next state of the whole sequencer
    always_comb
    begin
        d = q;
        halt = i_deep_sleep || !i_en;
        d.res_stb = 1'b0;
        d.oor = 1'b0;
        d.done = 1'b0;
        push = 1'b0;
        push_data = '{ch: q.ch, data: q.code};
        nx_cont = sarq_next(q.ch, i_ch_en, 1'b0);
        nx_first = sarq_next(q.ch, i_ch_en, 1'b1);
        fin = 1'b0;
        // conversion clock enable; divider keeps it at or under the maximum rate
        d.tick = (q.div == DIV_LAST);
        d.div = d.tick ? '0 : q.div + 1'b1;
        case (q.st)
            SARQ_IDLE:
            begin
                if (i_start && !halt)
                begin
                    d.scan_auto = i_auto;
                    d.cnt = '0;
                    if (i_auto)
                    begin
                        d.ch = nx_first[`SARQ_CH_W-1:0];
                        d.st = nx_first[`SARQ_CH_W] ? SARQ_SAMPLE : SARQ_IDLE;
                    end
                    else
                    begin
                        d.ch = i_fw_ch;
                        d.st = SARQ_SAMPLE;
                    end
                end
            end
            SARQ_SAMPLE:
            begin
                // window length comes from the channel being sampled
                if (q.tick)
                begin
                    d.cnt = q.cnt + 1'b1;
                    if (q.cnt == `SARQ_CNT_W'(i_samp_time[q.ch]))
                    begin
                        d.st = SARQ_CONV;
                        d.cnt = '0;
                        d.code = '0;
                        d.bitm = `SARQ_TRIAL_MSB;
                        d.dac = `SARQ_TRIAL_MSB;
                    end
                end
            end
            SARQ_CONV:
            begin
                // successive approximation, then settle to the full conversion length
                if (q.tick && q.cnt < TRIAL_N)
                begin
                    d.code = i_cmp ? q.dac : q.code;
                    d.bitm = q.bitm >> 1;
                    d.dac = d.code | d.bitm;
                    d.cnt = q.cnt + 1'b1;
                end
                else if (q.tick && q.cnt != CONV_LAST)
                begin
                    d.cnt = q.cnt + 1'b1;
                end
                else if (q.tick && fifo_rdy)
                begin
                    // a full fifo holds the sequencer here, so no result is dropped
                    fin = 1'b1;
                    push = 1'b1;
                    d.res[q.ch] = q.code;
                    d.res_stb = 1'b1;
                    d.oor = (q.code < i_range_lo) || (q.code > i_range_hi);
                    d.oor_ch = q.ch;
                    d.cnt = '0;
                    d.st = SARQ_IDLE;
                    if (q.scan_auto && nx_cont[`SARQ_CH_W])
                    begin
                        d.ch = nx_cont[`SARQ_CH_W-1:0];
                        d.st = SARQ_SAMPLE;
                    end
                    else
                    begin
                        d.done = 1'b1;
                        if (q.scan_auto && i_continuous && nx_first[`SARQ_CH_W])
                        begin
                            d.ch = nx_first[`SARQ_CH_W-1:0];
                            d.st = SARQ_SAMPLE;
                        end
                    end
                end
            end
            default:
            begin
                d.st = SARQ_IDLE;
            end
        endcase
        if (halt && !fin)
        begin
            d.st = SARQ_IDLE;
            d.cnt = '0;
        end
        d.samp = (d.st == SARQ_SAMPLE);
        d.busy = (d.st != SARQ_IDLE);
    end

    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            q <= '{st: SARQ_IDLE, default: '0};
        end
        else
        begin
            q <= d;
        end
    end

    // result stream towards software
    sarq_fifo #(.W($bits(sarq_res_t)), .DEPTH(`SARQ_FIFO_DEPTH)) u_fifo (
        .i_clk(i_clk),
        .i_rst_n(i_rst_n),
        .i_valid(push),
        .i_data(push_data),
        .o_ready(fifo_rdy),
        .o_valid(o_fifo_valid),
        .o_data(o_fifo_data),
        .i_ready(i_fifo_ready)
    );

    assign o_mux_sel = q.ch;
    assign o_sample = q.samp;
    assign o_dac = q.dac;
    assign o_busy = q.busy;
    assign o_res = q.res;
    assign o_res_stb = q.res_stb;
    assign o_oor_irq = q.oor;
    assign o_oor_ch = q.oor_ch;
    assign o_scan_done = q.done;

    // ----------------------------------------
    // checks
    // ----------------------------------------
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rst_n);
    logic [7:0] conv_cyc;
    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            conv_cyc <= '0;
        end
        else
        begin
            // saturates so that a long fifo stall cannot wrap it into a false short count
            if (q.st != SARQ_CONV)
            begin
                conv_cyc <= 8'h00;
            end
            else if (conv_cyc != 8'hFF)
            begin
                conv_cyc <= conv_cyc + 8'h01;
            end
        end
    end
    sequence s_result;
        o_res_stb ##0 (o_res[o_oor_ch] == $past(q.code));
    endsequence
    // conv_cyc excludes the storing cycle; that cycle and at least one sample cycle complete the minimum
    conv_length_a: assert property (fin |-> conv_cyc >= 8'(`SARQ_CONV_CLKS - 2) * 8'(CLK_DIV))
        else $error("conversion shorter than minimum");
    res_buffer_a: assert property (fin |=> s_result)
        else $error("result buffer not written");
    samp_window_a: assert property ($rose(o_sample) && !halt |-> o_sample [*2] or ##1 (q.st == SARQ_CONV))
        else $error("sample window collapsed");
    chan_mask_a: assert property ($rose(o_sample) && q.scan_auto |-> i_ch_en[o_mux_sel] || $changed(i_ch_en))
        else $error("disabled channel sampled");
    no_gap_a: assert property (fin && q.scan_auto && nx_cont[`SARQ_CH_W] && !halt |=> o_sample)
        else $error("switching gap between channels");
    fw_chan_a: assert property (q.st == SARQ_IDLE && i_start && !i_auto && !halt |=> o_mux_sel == $past(i_fw_ch))
        else $error("firmware channel not used");
    samp_own_a: assert property (q.st == SARQ_SAMPLE && q.tick && q.cnt == `SARQ_CNT_W'(i_samp_time[q.ch])
                                 |=> q.st == SARQ_CONV)
        else $error("channel sample time not applied");
    range_irq_a: assert property (fin && (q.code > i_range_hi || q.code < i_range_lo) |=> o_oor_irq && o_res_stb)
        else $error("out of range not flagged with result");
    sleep_halt_a: assert property (i_deep_sleep && !fin |=> !o_busy ##1 (!o_busy || !$past(i_deep_sleep)))
        else $error("sequencer ran in deep sleep");
    scan_end_a: assert property (fin && q.scan_auto && !nx_cont[`SARQ_CH_W] |=> o_scan_done)
        else $error("scan end not flagged");
endmodule

// ===== dv/sarq_analog_model.sv
// analog side model: per channel input levels behind the mux, ideal comparator
`timescale 1ns/1ps

// ----------------------------------------
// comparator of the selected input against the trial code
// ----------------------------------------
module sarq_analog_model (
    input wire logic [7:0][11:0] i_lvl,  // level of each channel, in codes
    input wire logic [2:0] i_sel,        // mux select from the sequencer
    input wire logic [11:0] i_dac,       // trial code from the sequencer
    output logic o_cmp                   // input at or above the trial code
);
    // an ideal comparator, so every bit decision is exact and results are predictable
    assign o_cmp = (i_lvl[i_sel] >= i_dac);
endmodule

// ===== dv/sar_adc_sequencer_control_tb.sv
// self-checking bench of the converter sequencer control
`timescale 1ns/1ps
`include "sarq_consts.svh"

module sar_adc_sequencer_control_tb;
    import sarq_pkg::*;
    // ----------------------------------------
    // signals
    // ----------------------------------------
    logic i_clk = 1'b0;
    logic i_rst_n = 1'b0;
    logic i_en = 1'b1;
    logic i_deep_sleep = 1'b0;
    logic i_auto = 1'b0;
    logic i_continuous = 1'b0;
    logic i_start = 1'b0;
    logic [7:0] i_ch_en = 8'h00;
    logic [2:0] i_fw_ch = 3'h0;
    logic [7:0][7:0] i_samp_time = '0;
    logic [11:0] i_range_lo = 12'h000;
    logic [11:0] i_range_hi = 12'hFFF;
    logic i_cmp;
    logic i_fifo_ready = 1'b1;
    logic [7:0][11:0] lvl = '0;
    logic [2:0] o_mux_sel;
    logic o_sample, o_busy, o_res_stb, o_oor_irq, o_scan_done, o_fifo_valid;
    logic [11:0] o_dac;
    logic [7:0][11:0] o_res;
    logic [2:0] o_oor_ch;
    sarq_res_t o_fifo_data;
    int err_total = 0;
    int n_tests = 0;
    int cyc = 0;
    int samp_cnt = 0;
    int samp_len [8];

    always #50 i_clk = ~i_clk;

    sarq_top dut (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_en(i_en), .i_deep_sleep(i_deep_sleep), .i_auto(i_auto),
        .i_continuous(i_continuous), .i_start(i_start), .i_ch_en(i_ch_en), .i_fw_ch(i_fw_ch),
        .i_samp_time(i_samp_time), .i_range_lo(i_range_lo), .i_range_hi(i_range_hi), .i_cmp(i_cmp),
        .o_mux_sel(o_mux_sel), .o_sample(o_sample), .o_dac(o_dac), .o_busy(o_busy), .o_res(o_res),
        .o_res_stb(o_res_stb), .o_oor_irq(o_oor_irq), .o_oor_ch(o_oor_ch), .o_scan_done(o_scan_done),
        .o_fifo_valid(o_fifo_valid), .o_fifo_data(o_fifo_data), .i_fifo_ready(i_fifo_ready));

    sarq_analog_model analog (.i_lvl(lvl), .i_sel(o_mux_sel), .i_dac(o_dac), .o_cmp(i_cmp));

    // cycle count and sample window length per channel, taken when the window closes
    always @(posedge i_clk)
    begin
        cyc <= cyc + 1;
        if (o_sample === 1'b1)
            samp_cnt <= samp_cnt + 1;
        else if (samp_cnt != 0)
        begin
            samp_len[o_mux_sel] <= samp_cnt;
            samp_cnt <= 0;
        end
    end

    // ----------------------------------------
    // shared tasks
    // ----------------------------------------
    task automatic end_sim();
        $display("comparisons %0d, mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            err_total++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    // bounded wait for a stored result, left at the falling edge where the strobe stands
    task automatic wait_stb(output int t);
        int k;
        for (k = 0; k < 200 && o_res_stb !== 1'b1; k++)
            @(negedge i_clk);
        if (o_res_stb !== 1'b1)
        begin
            err_total++;
            end_sim();
        end
        t = cyc;
    endtask

    // one start pulse; the start edge falls inside the call, on the first rising edge after t0 is taken
    task automatic go(input logic au, input logic [7:0] mask, input logic [2:0] ch, output int t0);
        @(negedge i_clk);
        i_auto = au;
        i_ch_en = mask;
        i_fw_ch = ch;
        i_start = 1'b1;
        t0 = cyc;
        @(negedge i_clk);
        i_start = 1'b0;
    endtask

    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    // firmware conversion of one channel with an empty scan mask
    task automatic t_fw();
        int t0, t1;
        lvl[5] = 12'hABC;
        i_samp_time[5] = 8'h03;
        go(1'b0, 8'h00, 3'h5, t0);
        wait_stb(t1);
        // one to take the start, four sample cycles, sixteen conversion cycles, one to store
        chk("fw_latency", 16'(t1 - t0), 16'd22);
        chk("fw_result", o_res[5], 16'h0ABC);
        chk("fw_window", 16'(samp_len[5]), 16'd4);
        chk("fw_res_other", o_res[0], 16'h0000);
        chk("fw_fifo", o_fifo_data, 16'h5ABC);
        chk("fw_mux", 16'(o_mux_sel), 16'h0005);
        chk("fw_dac", o_dac, 16'h0ABC);
        chk("fw_done", 16'(o_scan_done), 16'h0001);
    endtask

    // automatic scan over channels 0 2 5 7 with two out-of-range results
    task automatic t_scan();
        int chs [4] = '{0, 2, 5, 7};
        int st [4] = '{2, 5, 1, 0};
        logic [11:0] v [4] = '{12'h050, 12'h800, 12'h123, 12'hF00};
        logic [3:0] oor = 4'b1001;
        int t0, t1, i;
        i_range_lo = 12'h100;
        i_range_hi = 12'hE00;
        for (i = 0; i < 4; i++)
        begin
            lvl[chs[i]] = v[i];
            i_samp_time[chs[i]] = 8'(st[i]);
        end
        lvl[1] = 12'h777;
        go(1'b1, 8'hA5, 3'h1, t0);
        for (i = 0; i < 4; i++)
        begin
            wait_stb(t1);
            if (i > 0)
                chk("scan_gap", 16'(t1 - t0), 16'(st[i] + `SARQ_CONV_CLKS));
            t0 = t1;
            chk("scan_order", 16'(o_oor_ch), 16'(chs[i]));
            chk("scan_oor", 16'(o_oor_irq), 16'(oor[i]));
            chk("scan_done", 16'(o_scan_done), 16'(i == 3));
            chk("scan_res", o_res[chs[i]], 16'(v[i]));
            @(negedge i_clk);
            chk("scan_window", 16'(samp_len[chs[i]]), 16'(st[i] + 1));
        end
        @(negedge i_clk);
        chk("scan_stop", 16'(o_busy), 16'h0000);
        chk("scan_skip", o_res[1], 16'h0000);
    endtask

    // deep sleep aborts a scan and keeps new starts out
    task automatic t_sleep();
        int t0;
        go(1'b1, 8'hFF, 3'h0, t0);
        repeat (5) @(negedge i_clk);
        i_deep_sleep = 1'b1;
        repeat (2) @(negedge i_clk);
        chk("sleep_abort", {o_busy, o_sample}, 16'h0000);
        go(1'b1, 8'hFF, 3'h0, t0);
        repeat (3) @(negedge i_clk);
        chk("sleep_start", 16'(o_busy), 16'h0000);
        i_deep_sleep = 1'b0;
        // a disabled converter refuses starts the same way
        i_en = 1'b0;
        go(1'b1, 8'hFF, 3'h0, t0);
        repeat (3) @(negedge i_clk);
        chk("enable_off", 16'(o_busy), 16'h0000);
        i_en = 1'b1;
    endtask

    // continuous scan against a stalled consumer, then drain to empty
    task automatic t_fifo();
        int t0, n, k;
        i_fifo_ready = 1'b0;
        i_continuous = 1'b1;
        i_samp_time = '0;
        go(1'b1, 8'h03, 3'h0, t0);
        repeat (600) @(negedge i_clk);
        chk("fifo_full_busy", {o_busy, o_fifo_valid}, 16'h0003);
        chk("fifo_head", o_fifo_data, 16'(lvl[0]));
        i_continuous = 1'b0;
        i_fifo_ready = 1'b1;
        n = 0;
        for (k = 0; k < 400 && (o_fifo_valid !== 1'b0 || o_busy !== 1'b0); k++)
        begin
            n += (o_fifo_valid === 1'b1);
            @(negedge i_clk);
        end
        chk("fifo_empty", {o_busy, o_fifo_valid}, 16'h0000);
        chk("fifo_pops", 16'(n >= 16), 16'h0001);
    endtask

    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial
    begin
        repeat (12) @(negedge i_clk);
        chk("rst_busy", {o_busy, o_res_stb, o_fifo_valid}, 16'h0000);
        i_rst_n = 1'b1;
        t_fw();
        t_scan();
        t_sleep();
        t_fifo();
        end_sim();
    end
endmodule
